// File: hw/fsbr_device.sv
// What this block does
// - min period bound caps frame rate
// - periods counted in clock cycles
// - reads go upper byte then lower
// - write lower, upper, then commit max
// - min period writes within 0x7E0E..0xFFFF
// - reads return last written staged value
// - staged bounds unused until commit write
// - wait two frames before rewriting bounds
// - busy bit in extended config
// - max period at least min plus shutter
// - auto shutter capped at shutter bound
// - agc off uses shutter bound directly
// - firmware revision only when running download
// - reset values depend on firmware state
// - silicon revision readable at 0x01
// - 0x20 to 0x3C reserved
// - commit activates all three bounds together
// - commit busy for rest of current frame plus two complete frames
`timescale 1ns/1ns
`default_nettype none
module fsbr_device #(
  parameter logic [7:0] SILICON_REV = 8'h5A // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  fsbr_if.dev bus,
  // firmware state
  input wire logic fw_loaded,
  input wire logic [7:0] firmware_revision_bits,
  // exposure loop
  input wire logic [15:0] shutter_request,
  input wire logic [15:0] frame_period_request,
  output logic [15:0] shutter_value,
  output logic [15:0] frame_period,
  output logic frame_tick,
  output logic bounds_busy
);
  logic [7:0] max_lo_r;
  logic [7:0] max_hi_r;
  logic [7:0] min_lo_r;
  logic [7:0] min_hi_r;
  logic [7:0] sh_lo_r;
  logic [7:0] sh_hi_r;
  logic [1:0] ext_cfg_r;
  logic [15:0] act_max_r;
  logic [15:0] act_min_r;
  logic [15:0] act_sh_r;
  logic pend_r;
  logic [1:0] frames_left_r;
  logic fw_prev_r;
  logic [15:0] frame_cnt_r;
  logic [15:0] shutter_r;
  logic [7:0] rdata_r;
  logic ack_r;

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if (r < lo) begin
      r = lo;
    end
    if (r > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // bus decode
  wire wr = bus.req & bus.we;
  wire rd = bus.req & ~bus.we;
  wire wr_max_lo = wr && bus.addr == fsbr_pkg::ADDR_MAX_PERIOD_LO;
  wire wr_max_hi = wr && bus.addr == fsbr_pkg::ADDR_MAX_PERIOD_HI;
  wire wr_min_lo = wr && bus.addr == fsbr_pkg::ADDR_MIN_PERIOD_LO;
  wire wr_min_hi = wr && bus.addr == fsbr_pkg::ADDR_MIN_PERIOD_HI;
  wire wr_sh_lo = wr && bus.addr == fsbr_pkg::ADDR_MAX_SHUTTER_LO;
  wire wr_sh_hi = wr && bus.addr == fsbr_pkg::ADDR_MAX_SHUTTER_HI;
  wire wr_ext = wr && bus.addr == fsbr_pkg::ADDR_EXT_CONFIG;
  // commit completes on the upper max byte, after its lower byte
  wire commit = wr_max_hi;
  wire fw_rise = fw_loaded & ~fw_prev_r;
  wire agc_off = ext_cfg_r[fsbr_pkg::EXT_AGC_OFF_BIT];
  wire manual_rate = ext_cfg_r[fsbr_pkg::EXT_MANUAL_RATE_BIT];
  wire busy = pend_r | (frames_left_r != 2'h0);

  // frame length in clock cycles, rate = clk / period
  wire [15:0] period_auto = clamp16(frame_period_request, act_min_r, act_max_r);
  wire [15:0] period_sel = manual_rate ? act_max_r : period_auto;
  wire [15:0] period_eff = (period_sel == 16'h0000) ? 16'h0001 : period_sel;
  wire frame_end = frame_cnt_r >= period_eff - 16'h0001;

  // shutter cap, or fixed value with agc off
  wire [15:0] shutter_auto = (shutter_request > act_sh_r) ? act_sh_r : shutter_request;
  wire [15:0] shutter_nxt = agc_off ? act_sh_r : shutter_auto;

  // read mux: staged bytes, not active values
  wire [7:0] ext_rd = {busy, 5'h00, ext_cfg_r};
  wire [7:0] fw_rd = fw_loaded ? firmware_revision_bits : fsbr_pkg::FIRMWARE_REV_NONE;
  wire in_reserved = bus.addr >= fsbr_pkg::ADDR_RESERVED_FIRST &&
                     bus.addr <= fsbr_pkg::ADDR_RESERVED_LAST;
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (!in_reserved) begin
      unique case (bus.addr)
        fsbr_pkg::ADDR_SILICON_REV: rd_mux = SILICON_REV;
        fsbr_pkg::ADDR_EXT_CONFIG: rd_mux = ext_rd;
        fsbr_pkg::ADDR_MAX_PERIOD_LO: rd_mux = max_lo_r;
        fsbr_pkg::ADDR_MAX_PERIOD_HI: rd_mux = max_hi_r;
        fsbr_pkg::ADDR_MIN_PERIOD_LO: rd_mux = min_lo_r;
        fsbr_pkg::ADDR_MIN_PERIOD_HI: rd_mux = min_hi_r;
        fsbr_pkg::ADDR_MAX_SHUTTER_LO: rd_mux = sh_lo_r;
        fsbr_pkg::ADDR_MAX_SHUTTER_HI: rd_mux = sh_hi_r;
        fsbr_pkg::ADDR_FIRMWARE_REV: rd_mux = fw_rd;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // bus answer one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      ack_r <= bus.req;
      if (rd) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign bus.ack = ack_r;
  assign bus.rdata = rdata_r;

  // staged max period and config
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      max_lo_r <= fsbr_pkg::RST_MAX_PERIOD_LO;
      max_hi_r <= fsbr_pkg::RST_MAX_PERIOD_HI;
      ext_cfg_r <= fsbr_pkg::EXT_CONFIG_RESET;
      fw_prev_r <= 1'b0;
    end else begin
      fw_prev_r <= fw_loaded;
      if (wr_max_lo) begin
        max_lo_r <= bus.wdata;
      end
      if (wr_max_hi) begin
        max_hi_r <= bus.wdata;
      end
      if (wr_ext) begin
        ext_cfg_r <= bus.wdata[1:0];
      end
    end
  end

  // staged min period and shutter; firmware load reloads min period and lower shutter byte defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      min_lo_r <= fsbr_pkg::RST_MIN_PERIOD_LO_PRE;
      min_hi_r <= fsbr_pkg::RST_MIN_PERIOD_HI_PRE;
      sh_lo_r <= fsbr_pkg::RST_MAX_SHUTTER_LO_PRE;
      sh_hi_r <= fsbr_pkg::RST_MAX_SHUTTER_HI;
    end else if (fw_rise) begin
      min_lo_r <= fsbr_pkg::RST_MIN_PERIOD_LO_POST;
      min_hi_r <= fsbr_pkg::RST_MIN_PERIOD_HI_POST;
      sh_lo_r <= fsbr_pkg::RST_MAX_SHUTTER_LO_POST;
    end else begin
      if (wr_min_lo) begin
        min_lo_r <= bus.wdata;
      end
      if (wr_min_hi) begin
        min_hi_r <= bus.wdata;
      end
      if (wr_sh_lo) begin
        sh_lo_r <= bus.wdata;
      end
      if (wr_sh_hi) begin
        sh_hi_r <= bus.wdata;
      end
    end
  end

  // active bounds change at the first frame end after a commit; firmware load reloads active min period and shutter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_max_r <= {fsbr_pkg::RST_MAX_PERIOD_HI, fsbr_pkg::RST_MAX_PERIOD_LO};
      act_min_r <= {fsbr_pkg::RST_MIN_PERIOD_HI_PRE, fsbr_pkg::RST_MIN_PERIOD_LO_PRE};
      act_sh_r <= {fsbr_pkg::RST_MAX_SHUTTER_HI, fsbr_pkg::RST_MAX_SHUTTER_LO_PRE};
    end else if (fw_rise) begin
      act_min_r <= {fsbr_pkg::RST_MIN_PERIOD_HI_POST, fsbr_pkg::RST_MIN_PERIOD_LO_POST};
      act_sh_r <= {fsbr_pkg::RST_MAX_SHUTTER_HI, fsbr_pkg::RST_MAX_SHUTTER_LO_POST};
    end else if (pend_r && frame_end) begin
      act_max_r <= {max_hi_r, max_lo_r};
      act_min_r <= {min_hi_r, min_lo_r};
      act_sh_r <= {sh_hi_r, sh_lo_r};
    end
  end

  // settle tracking: pending, then two complete frames
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
      frames_left_r <= 2'h0;
    end else if (commit) begin
      pend_r <= 1'b1;
      frames_left_r <= 2'h0;
    end else if (frame_end) begin
      if (pend_r) begin
        pend_r <= 1'b0;
        frames_left_r <= fsbr_pkg::SETTLE_FRAMES;
      end else if (frames_left_r != 2'h0) begin
        frames_left_r <= frames_left_r - 2'h1;
      end
    end
  end

  // frame timer and shutter output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt_r <= 16'h0000;
      shutter_r <= 16'h0000;
    end else begin
      frame_cnt_r <= frame_end ? 16'h0000 : frame_cnt_r + 16'h0001;
      shutter_r <= shutter_nxt;
    end
  end

  assign frame_tick = frame_end;
  assign frame_period = act_max_r == 16'h0000 ? 16'h0000 : period_eff;
  assign shutter_value = shutter_r;
  assign bounds_busy = busy;
endmodule
`default_nettype wire

// File: hw/fsbr_host.sv
`timescale 1ns/1ns
`default_nettype none
module fsbr_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  fsbr_if.host bus,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [1:0] cmd_sel,
  input wire logic [15:0] cmd_min_period,
  input wire logic [15:0] cmd_max_shutter,
  input wire logic [15:0] cmd_max_period,
  input wire logic [1:0] cmd_config,
  // response
  output logic rsp_valid,
  output logic rsp_error,
  output logic [15:0] rsp_data
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_POLL = 5'b00010,
    S_PWAIT = 5'b00100,
    S_ISSUE = 5'b01000,
    S_IWAIT = 5'b10000
  } fsbr_state_e;

  fsbr_state_e state_r;
  logic [1:0] op_r;
  logic [15:0] min_r;
  logic [15:0] sh_r;
  logic [15:0] max_r;
  logic [2:0] step_r;
  logic post_r;
  logic [7:0] hi_r;
  logic [6:0] addr_r;
  logic [7:0] wdata_r;
  logic we_r;
  logic rsp_valid_r;
  logic rsp_error_r;
  logic [15:0] rsp_data_r;

  // lower byte first, upper next, max period last as the commit
  function automatic logic [6:0] bound_addr(input logic [2:0] s);
    logic [6:0] a;
    a = fsbr_pkg::ADDR_MAX_PERIOD_HI;
    unique case (s)
      3'h0: a = fsbr_pkg::ADDR_MIN_PERIOD_LO;
      3'h1: a = fsbr_pkg::ADDR_MIN_PERIOD_HI;
      3'h2: a = fsbr_pkg::ADDR_MAX_SHUTTER_LO;
      3'h3: a = fsbr_pkg::ADDR_MAX_SHUTTER_HI;
      3'h4: a = fsbr_pkg::ADDR_MAX_PERIOD_LO;
      default: a = fsbr_pkg::ADDR_MAX_PERIOD_HI;
    endcase
    return a;
  endfunction

  function automatic logic [7:0] bound_data(input logic [2:0] s, input logic [15:0] mn,
                                            input logic [15:0] sh, input logic [15:0] mx);
    logic [7:0] d;
    d = mx[15:8];
    unique case (s)
      3'h0: d = mn[7:0];
      3'h1: d = mn[15:8];
      3'h2: d = sh[7:0];
      3'h3: d = sh[15:8];
      3'h4: d = mx[7:0];
      default: d = mx[15:8];
    endcase
    return d;
  endfunction

  // upper address of a pair; lower is one below
  function automatic logic [6:0] pair_hi(input logic [1:0] sel);
    logic [6:0] a;
    a = fsbr_pkg::ADDR_MAX_SHUTTER_HI;
    if (sel == fsbr_pkg::SEL_MAX_PERIOD) begin
      a = fsbr_pkg::ADDR_MAX_PERIOD_HI;
    end else if (sel == fsbr_pkg::SEL_MIN_PERIOD) begin
      a = fsbr_pkg::ADDR_MIN_PERIOD_HI;
    end
    return a;
  endfunction

  wire [16:0] need_max = {1'b0, cmd_min_period} + {1'b0, cmd_max_shutter};
  wire bounds_ok = cmd_min_period >= fsbr_pkg::MIN_PERIOD_FLOOR &&
                   {1'b0, cmd_max_period} >= need_max;
  wire take = cmd_valid && state_r == S_IDLE;
  wire is_read = op_r == fsbr_pkg::OP_READ_PAIR;
  wire is_bounds = op_r == fsbr_pkg::OP_WRITE_BOUNDS;
  wire dev_busy = bus.rdata[fsbr_pkg::EXT_BUSY_BIT];

  assign cmd_ready = state_r == S_IDLE;
  assign bus.req = state_r == S_POLL || state_r == S_ISSUE;
  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.we = we_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_error = rsp_error_r;
  assign rsp_data = rsp_data_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      op_r <= fsbr_pkg::OP_READ_PAIR;
      min_r <= 16'h0000;
      sh_r <= 16'h0000;
      max_r <= 16'h0000;
      step_r <= 3'h0;
      post_r <= 1'b0;
      hi_r <= 8'h00;
      addr_r <= 7'h00;
      wdata_r <= 8'h00;
      we_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_error_r <= 1'b0;
      rsp_data_r <= 16'h0000;
    end else begin
      rsp_valid_r <= 1'b0;
      rsp_error_r <= 1'b0;
      unique case (state_r)
        S_IDLE: begin
          if (take) begin
            op_r <= cmd_op;
            min_r <= cmd_min_period;
            sh_r <= cmd_max_shutter;
            max_r <= cmd_max_period;
            step_r <= 3'h0;
            post_r <= 1'b0;
            if (cmd_op == fsbr_pkg::OP_WRITE_BOUNDS) begin
              if (bounds_ok) begin
                addr_r <= fsbr_pkg::ADDR_EXT_CONFIG;
                we_r <= 1'b0;
                state_r <= S_POLL;
              end else begin
                rsp_error_r <= 1'b1;
              end
            end else if (cmd_op == fsbr_pkg::OP_WRITE_CONFIG) begin
              addr_r <= fsbr_pkg::ADDR_EXT_CONFIG;
              wdata_r <= {6'h00, cmd_config};
              we_r <= 1'b1;
              state_r <= S_ISSUE;
            end else begin
              addr_r <= pair_hi(cmd_sel);
              we_r <= 1'b0;
              state_r <= S_ISSUE;
            end
          end
        end
        S_POLL: state_r <= S_PWAIT;
        S_PWAIT: begin
          if (bus.ack) begin
            if (dev_busy) begin
              state_r <= S_POLL;
            end else if (post_r) begin
              rsp_valid_r <= 1'b1;
              state_r <= S_IDLE;
            end else begin
              addr_r <= bound_addr(step_r);
              wdata_r <= bound_data(step_r, min_r, sh_r, max_r);
              we_r <= 1'b1;
              state_r <= S_ISSUE;
            end
          end
        end
        S_ISSUE: state_r <= S_IWAIT;
        S_IWAIT: begin
          if (bus.ack) begin
            if (is_read && step_r == 3'h0) begin
              hi_r <= bus.rdata;
              addr_r <= addr_r - 7'h01;
              step_r <= 3'h1;
              state_r <= S_ISSUE;
            end else if (is_read) begin
              rsp_data_r <= {hi_r, bus.rdata};
              rsp_valid_r <= 1'b1;
              state_r <= S_IDLE;
            end else if (is_bounds && step_r != fsbr_pkg::LAST_BOUND_STEP) begin
              addr_r <= bound_addr(step_r + 3'h1);
              wdata_r <= bound_data(step_r + 3'h1, min_r, sh_r, max_r);
              step_r <= step_r + 3'h1;
              state_r <= S_ISSUE;
            end else if (is_bounds) begin
              post_r <= 1'b1;
              addr_r <= fsbr_pkg::ADDR_EXT_CONFIG;
              we_r <= 1'b0;
              state_r <= S_POLL;
            end else begin
              rsp_valid_r <= 1'b1;
              state_r <= S_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: hw/fsbr_if.sv
`timescale 1ns/1ns
`default_nettype none
interface fsbr_if;
  logic req;
  logic we;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;

  modport dev (
    input req,
    input we,
    input addr,
    input wdata,
    output rdata,
    output ack
  );

  modport host (
    output req,
    output we,
    output addr,
    output wdata,
    input rdata,
    input ack
  );
endinterface
`default_nettype wire

// File: hw/fsbr_pkg.sv
package fsbr_pkg;
  // register addresses
  localparam logic [6:0] ADDR_SILICON_REV = 7'h01;
  localparam logic [6:0] ADDR_EXT_CONFIG = 7'h0B;
  localparam logic [6:0] ADDR_MAX_PERIOD_LO = 7'h19;
  localparam logic [6:0] ADDR_MAX_PERIOD_HI = 7'h1A;
  localparam logic [6:0] ADDR_MIN_PERIOD_LO = 7'h1B;
  localparam logic [6:0] ADDR_MIN_PERIOD_HI = 7'h1C;
  localparam logic [6:0] ADDR_MAX_SHUTTER_LO = 7'h1D;
  localparam logic [6:0] ADDR_MAX_SHUTTER_HI = 7'h1E;
  localparam logic [6:0] ADDR_FIRMWARE_REV = 7'h1F;
  localparam logic [6:0] ADDR_RESERVED_FIRST = 7'h20;
  localparam logic [6:0] ADDR_RESERVED_LAST = 7'h3C;

  // extended configuration fields
  localparam int EXT_AGC_OFF_BIT = 0;
  localparam int EXT_MANUAL_RATE_BIT = 1;
  localparam int EXT_BUSY_BIT = 7;
  localparam logic [1:0] EXT_CONFIG_RESET = 2'h0;

  // reset values, before and after firmware download
  localparam logic [7:0] RST_MAX_PERIOD_LO = 8'hE0;
  localparam logic [7:0] RST_MAX_PERIOD_HI = 8'h2E;
  localparam logic [7:0] RST_MIN_PERIOD_LO_PRE = 8'hAC;
  localparam logic [7:0] RST_MIN_PERIOD_LO_POST = 8'h7E;
  localparam logic [7:0] RST_MIN_PERIOD_HI_PRE = 8'h0D;
  localparam logic [7:0] RST_MIN_PERIOD_HI_POST = 8'h0E;
  localparam logic [7:0] RST_MAX_SHUTTER_LO_PRE = 8'h8C;
  localparam logic [7:0] RST_MAX_SHUTTER_LO_POST = 8'h00;
  localparam logic [7:0] RST_MAX_SHUTTER_HI = 8'h20;
  localparam logic [7:0] FIRMWARE_REV_NONE = 8'h00;

  // write limits and settling
  localparam logic [15:0] MIN_PERIOD_FLOOR = 16'h7E0E;
  localparam logic [1:0] SETTLE_FRAMES = 2'h2;

  // host commands
  localparam logic [1:0] OP_READ_PAIR = 2'h0;
  localparam logic [1:0] OP_WRITE_BOUNDS = 2'h1;
  localparam logic [1:0] OP_WRITE_CONFIG = 2'h2;
  localparam logic [1:0] SEL_MAX_PERIOD = 2'h0;
  localparam logic [1:0] SEL_MIN_PERIOD = 2'h1;
  localparam logic [1:0] SEL_MAX_SHUTTER = 2'h2;
  localparam logic [2:0] LAST_BOUND_STEP = 3'h5;
endpackage

// File: sim/fsbr_checker.sv
`timescale 1ns/1ns
`default_nettype none
module fsbr_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic req,
  input wire logic we,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack
);
  // two frames of the shortest legal period
  localparam int SETTLE_MIN = 2 * int'(fsbr_pkg::MIN_PERIOD_FLOOR);
  logic [6:0] last_w_r;
  logic [6:0] last_r_r;
  logic [16:0] settle_r;
  logic [7:0] seen_r;
  logic [7:0] expect_r;
  logic [7:0] shadow_r [0:7];
  wire logic wr_hit;
  wire logic rd_hit;
  wire logic bound_addr;
  wire logic commit;
  wire logic settling;
  assign wr_hit = req && we;
  assign rd_hit = req && !we;
  assign bound_addr = addr >= fsbr_pkg::ADDR_MAX_PERIOD_LO && addr <= fsbr_pkg::ADDR_MAX_SHUTTER_HI;
  assign commit = wr_hit && addr == fsbr_pkg::ADDR_MAX_PERIOD_HI;
  assign settling = settle_r != 17'h00000;

  always_ff @(posedge clk) begin
    if (wr_hit && bound_addr) begin
      shadow_r[addr[2:0]] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_w_r <= 7'h00;
      last_r_r <= 7'h00;
      settle_r <= 17'h00000;
      seen_r <= 8'h00;
      expect_r <= 8'h00;
    end else begin
      if (wr_hit) last_w_r <= addr;
      if (rd_hit) last_r_r <= addr;
      if (rd_hit) expect_r <= shadow_r[addr[2:0]];
      if (wr_hit && bound_addr) seen_r[addr[2:0]] <= 1'b1;
      if (commit) settle_r <= 17'h00001;
      else if (settling && settle_r < SETTLE_MIN) settle_r <= settle_r + 17'h00001;
      else settle_r <= 17'h00000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ack_timing: assert property (req |=> ack)
    else $error("ack missing one cycle after req");
  a_ack_cause: assert property (ack |-> $past(req))
    else $error("ack without a request");
  a_req_gap: assert property (req |=> !req)
    else $error("requests back to back");
  a_read_order: assert property (rd_hit && addr inside {7'h19, 7'h1B, 7'h1D}
    |-> last_r_r == addr + 7'h01)
    else $error("lower byte read without upper first");
  a_write_order: assert property (wr_hit && addr inside {7'h1A, 7'h1C, 7'h1E}
    |-> last_w_r == addr - 7'h01)
    else $error("upper byte written without lower first");
  a_settle_quiet: assert property (settling |-> !(wr_hit && bound_addr))
    else $error("bound write during settle");
  a_busy_shown: assert property (rd_hit && addr == fsbr_pkg::ADDR_EXT_CONFIG && settling
    |=> rdata[fsbr_pkg::EXT_BUSY_BIT])
    else $error("busy not shown while settling");
  a_staged_readback: assert property (rd_hit && bound_addr && seen_r[addr[2:0]]
    |=> rdata == expect_r)
    else $error("readback differs from last write");
endmodule
`default_nettype wire

// File: sim/tb_frame_shutter_bound_regs.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_frame_shutter_bound_regs;
  typedef struct {
    logic [1:0] op, sel, cfg;
    logic [15:0] mn, sh, mx;
    logic err;
    logic [15:0] data;
  } fsbr_row_s;
  localparam logic [7:0] REV_B = 8'hA7; // arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fw_a = 1'b0;
  logic fw_b = 1'b0;
  logic [7:0] fwrev = 8'h3C;
  logic [15:0] sreq = 16'h0100;
  logic [15:0] preq = 16'h0000;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0, cmd_sel = 2'h0, cmd_cfg = 2'h0;
  logic [15:0] cmd_mn = 16'h0000, cmd_sh = 16'h0000, cmd_mx = 16'h0000;
  logic cmd_ready, rsp_valid, rsp_error, frame_tick, bounds_busy, got_err;
  logic [15:0] rsp_data, shutter_value, frame_period, frame_period_b, got_data;
  logic [7:0] bq;
  int err_total = 0, check_count = 0, cyc = 0, busy_ticks = 0, n;
  fsbr_row_s rows [6];
  fsbr_if bus_a ();
  fsbr_if bus_b ();
  fsbr_device i_fsbr_device (.clk(clk), .rst_n(rst_n), .bus(bus_a), .fw_loaded(fw_a),
    .firmware_revision_bits(fwrev), .shutter_request(sreq), .frame_period_request(preq),
    .shutter_value(shutter_value), .frame_period(frame_period), .frame_tick(frame_tick),
    .bounds_busy(bounds_busy));
  fsbr_device #(.SILICON_REV(REV_B)) i_fsbr_device_b (.clk(clk), .rst_n(rst_n), .bus(bus_b),
    .fw_loaded(fw_b), .firmware_revision_bits(fwrev), .shutter_request(sreq),
    .frame_period_request(preq), .shutter_value(), .frame_period(frame_period_b),
    .frame_tick(), .bounds_busy());
  fsbr_host i_fsbr_host (.clk(clk), .rst_n(rst_n), .bus(bus_a), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_sel(cmd_sel), .cmd_min_period(cmd_mn),
    .cmd_max_shutter(cmd_sh), .cmd_max_period(cmd_mx), .cmd_config(cmd_cfg),
    .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_data(rsp_data));
  fsbr_checker i_fsbr_checker (.clk(clk), .rst_n(rst_n), .req(bus_a.req), .we(bus_a.we),
    .addr(bus_a.addr), .wdata(bus_a.wdata), .rdata(bus_a.rdata), .ack(bus_a.ack));

  always #50 clk = ~clk;

  // settled sampling for the busy window
  always @(negedge clk) begin
    if (bounds_busy === 1'b1 && frame_tick === 1'b1) busy_ticks++;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      summarize();
    end
  end

  task summarize;
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task run_cmd(input logic [1:0] op, sel, cfg, input logic [15:0] mn, sh, mx, input int lim);
    int k;
    @(posedge clk);
    #1;
    cmd_op = op;
    cmd_sel = sel;
    cmd_cfg = cfg;
    cmd_mn = mn;
    cmd_sh = sh;
    cmd_mx = mx;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    for (k = 0; k < lim; k++) begin
      if (rsp_valid === 1'b1 || rsp_error === 1'b1) break;
      @(posedge clk);
      #1;
    end
    if (k == lim) err_total++;
    got_err = rsp_error;
    got_data = rsp_data;
  endtask

  // one-cycle request on the second port
  task bop(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    bus_b.req = 1'b1;
    bus_b.we = w;
    bus_b.addr = a;
    bus_b.wdata = d;
    @(posedge clk);
    #1;
    bus_b.req = 1'b0;
    `CHK(bus_b.ack, 1'b1);
    bq = bus_b.rdata;
  endtask

  task rdb(input logic [6:0] a, input logic [7:0] e);
    bop(1'b0, a, 8'h00);
    `CHK(bq, e);
  endtask

  initial begin
    rows[0] = '{2'h0, 2'h0, 2'h0, 16'h0000, 16'h0000, 16'h0000, 1'b0, 16'h2EE0};
    rows[1] = '{2'h0, 2'h1, 2'h0, 16'h0000, 16'h0000, 16'h0000, 1'b0, 16'h0DAC};
    rows[2] = '{2'h0, 2'h2, 2'h0, 16'h0000, 16'h0000, 16'h0000, 1'b0, 16'h208C};
    rows[3] = '{2'h1, 2'h0, 2'h0, 16'h7E0D, 16'h0010, 16'hFFFF, 1'b1, 16'h208C};
    rows[4] = '{2'h1, 2'h0, 2'h0, 16'h7E0E, 16'h1000, 16'h8E0D, 1'b1, 16'h208C};
    rows[5] = '{2'h2, 2'h0, 2'h1, 16'h0000, 16'h0000, 16'h0000, 1'b0, 16'h208C};
    bus_b.req = 1'b0;
    bus_b.we = 1'b0;
    bus_b.addr = 7'h00;
    bus_b.wdata = 8'h00;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    rdb(7'h1F, 8'h00);
    rdb(7'h1C, 8'h0D);
    rdb(7'h1D, 8'h8C);
    rdb(7'h01, REV_B);
    bop(1'b1, 7'h20, 8'hFF);
    rdb(7'h20, 8'h00);
    bop(1'b1, 7'h3C, 8'hFF);
    rdb(7'h3C, 8'h00);
    fw_b = 1'b1;
    rdb(7'h1F, 8'h3C);
    rdb(7'h1C, 8'h0E);
    rdb(7'h1B, 8'h7E);
    rdb(7'h1D, 8'h00);
    bop(1'b1, 7'h1B, 8'h34);
    bop(1'b1, 7'h1C, 8'h92);
    rdb(7'h1C, 8'h92);
    `CHK(frame_period_b, 16'h0E7E);
    for (int i = 0; i < 6; i++) begin
      run_cmd(rows[i].op, rows[i].sel, rows[i].cfg, rows[i].mn, rows[i].sh, rows[i].mx, 20);
      `CHK(got_err, rows[i].err);
      `CHK(got_data, rows[i].data);
    end
    repeat (3) @(posedge clk);
    #1 `CHK(shutter_value, 16'h208C);
    run_cmd(2'h2, 2'h0, 2'h0, 16'h0000, 16'h0000, 16'h0000, 20);
    repeat (3) @(posedge clk);
    #1 `CHK(shutter_value, 16'h0100);
    sreq = 16'hFFFF;
    repeat (3) @(posedge clk);
    #1 `CHK(shutter_value, 16'h208C);
    `CHK(frame_period, 16'h0DAC);
    preq = 16'hFFFF;
    #1 `CHK(frame_period, 16'h2EE0);
    preq = 16'h0000;
    run_cmd(2'h2, 2'h0, 2'h2, 16'h0000, 16'h0000, 16'h0000, 20);
    `CHK(frame_period, 16'h2EE0);
    run_cmd(2'h2, 2'h0, 2'h0, 16'h0000, 16'h0000, 16'h0000, 20);
    `CHK(frame_period, 16'h0DAC);
    for (n = 0; n < 5000 && frame_tick !== 1'b1; n++) @(posedge clk) #1;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (frame_tick !== 1'b1 && n < 5000);
    `CHK(16'(n), 16'h0DAC);
    fork
      run_cmd(2'h1, 2'h0, 2'h0, 16'h7E0E, 16'h1000, 16'h8E0E, 80000);
      begin
        for (n = 0; n < 5000 && bounds_busy !== 1'b1; n++) @(posedge clk) #1;
        `CHK(frame_period, 16'h0DAC);
        for (n = 0; n < 5000 && frame_tick !== 1'b1; n++) @(posedge clk) #1;
        @(posedge clk);
        #1 `CHK(frame_period, 16'h7E0E);
        repeat (2) @(posedge clk);
        #1 `CHK(shutter_value, 16'h1000);
      end
    join
    `CHK(got_err, 1'b0);
    `CHK(busy_ticks, 3);
    `CHK(bounds_busy, 1'b0);
    run_cmd(2'h0, 2'h1, 2'h0, 16'h0000, 16'h0000, 16'h0000, 20);
    `CHK(got_data, 16'h7E0E);
    run_cmd(2'h0, 2'h2, 2'h0, 16'h0000, 16'h0000, 16'h0000, 20);
    `CHK(got_data, 16'h1000);
    @(posedge clk);
    #1 rst_n = 1'b0;
    #1 `CHK(shutter_value, 16'h0000);
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    run_cmd(2'h0, 2'h1, 2'h0, 16'h0000, 16'h0000, 16'h0000, 20);
    `CHK(got_data, 16'h0DAC);
    summarize();
  end
endmodule
`default_nettype wire
